// [logic/plc_ctrl.sv]
/*
 pll control and lock logic: enable/reset, detector gating, counter limits,
 lock timing and toggled divided clocks on three outputs.
 assumes control pins are asynchronous; reference is a dedicated clock pin
 sampled as a level (behavioural model, no analog loop).
*/
`include "plc_defs.svh"
module plc_ctrl #(
    parameter int LOCK_CYC = `PLC_LOCK_DFLT_CYC
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic loop_run_en_i,
    input wire logic counter_clear_i,
    input wire logic detector_en_i,
    input wire logic reference_clock_in,
    input wire logic [5:0] mult_i,
    input wire logic [5:0] prescale_i,
    input wire logic [5:0] internal_out_divider_a_i,
    input wire logic [5:0] internal_out_divider_b_i,
    input wire logic [5:0] external_out_divider_i,
    output logic clk_out_a_o,
    output logic clk_out_b_o,
    output logic external_clock_output_o,
    output logic locked_o,
    output logic corr_up_o,
    output logic corr_dn_o,
    output logic cfg_err_o
);
    ////////////////////////////////////////////////////////////////////////
    // range checks and synchronisers
    function automatic logic in_rng(input logic [5:0] v, input logic [5:0] lo,
                                    input logic [5:0] hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction

    typedef struct packed {
        logic [1:0] run_s;
        logic [1:0] clr_s;
        logic [1:0] pfd_s;
        logic [1:0] ref_s;
        logic ref_d;
        plc_pkg::plc_state_t st;
        logic [31:0] cnt;
        logic [5:0] mult;
        logic [5:0] pre;
        logic [5:0] div_a;
        logic [5:0] div_b;
        logic [5:0] div_e;
        logic oa;
        logic ob;
        logic oe;
        logic lock;
        logic up;
        logic dn;
        logic err;
    } plc_st_t;
    plc_st_t s_r;
    plc_st_t s_nxt;

    plc_div_if ifa();
    plc_div_if ifb();
    plc_div_if ife();
    logic active;
    logic cfg_ok;
    logic ref_rise;
    assign active = s_r.run_s[1] && !s_r.clr_s[1];
    assign ref_rise = s_r.ref_s[1] && !s_r.ref_d;
    assign cfg_ok = in_rng(mult_i, `PLC_MULT_MIN, `PLC_MULT_MAX) && // R9
        in_rng(prescale_i, `PLC_DIV_MIN, `PLC_DIV_MAX) && // R12
        in_rng(internal_out_divider_a_i, `PLC_DIV_MIN, `PLC_DIV_MAX) &&
        in_rng(internal_out_divider_b_i, `PLC_DIV_MIN, `PLC_DIV_MAX) &&
        in_rng(external_out_divider_i, `PLC_DIV_MIN, `PLC_DIV_MAX);
    // only ticks when the loop is on; a stopped divider holds its count at zero
    assign ifa.run = s_r.st != plc_pkg::PLC_ST_OFF;
    assign ifb.run = s_r.st != plc_pkg::PLC_ST_OFF;
    assign ife.run = s_r.st != plc_pkg::PLC_ST_OFF;
    assign ifa.ratio = s_r.div_a;
    assign ifb.ratio = s_r.div_b;
    assign ife.ratio = s_r.div_e;

    plc_divider u_div_a (.clk_i(clk_i), .arst_n_i(arst_n_i), .d(ifa.div));
    plc_divider u_div_b (.clk_i(clk_i), .arst_n_i(arst_n_i), .d(ifb.div));
    plc_divider u_div_e (.clk_i(clk_i), .arst_n_i(arst_n_i), .d(ife.div));

    ////////////////////////////////////////////////////////////////////////
    // state update
    always_comb begin
        s_nxt = s_r;
        s_nxt.run_s = {s_r.run_s[0], loop_run_en_i}; // R6
        s_nxt.clr_s = {s_r.clr_s[0], counter_clear_i};
        s_nxt.pfd_s = {s_r.pfd_s[0], detector_en_i};
        s_nxt.ref_s = {s_r.ref_s[0], reference_clock_in}; // R8
        s_nxt.ref_d = s_r.ref_s[1];
        s_nxt.up = 1'b0;
        s_nxt.dn = 1'b0;
        unique case (s_r.st)
            plc_pkg::PLC_ST_OFF: begin
                if (active) begin
                    s_nxt.err = !cfg_ok;
                    if (cfg_ok) begin
                        // settings latched only here so a live change cannot glitch
                        s_nxt.mult = mult_i; // R9
                        s_nxt.pre = prescale_i; // R12
                        s_nxt.div_a = internal_out_divider_a_i;
                        s_nxt.div_b = internal_out_divider_b_i;
                        s_nxt.div_e = external_out_divider_i;
                        s_nxt.cnt = 32'h0000_0000;
                        s_nxt.st = plc_pkg::PLC_ST_ACQ; // R2 R4
                    end
                end
            end
            plc_pkg::PLC_ST_ACQ: begin
                s_nxt.cnt = s_r.cnt + 32'h0000_0001;
                if (s_r.cnt + 32'h0000_0001 >= 32'(LOCK_CYC)) begin
                    s_nxt.st = plc_pkg::PLC_ST_LOCK; // R10
                end
            end
            plc_pkg::PLC_ST_LOCK: begin
                s_nxt.cnt = s_r.cnt;
            end
            default: begin
                s_nxt.st = plc_pkg::PLC_ST_OFF;
            end
        endcase
        // correction pulses on reference edges only while detector enabled
        if (s_r.st != plc_pkg::PLC_ST_OFF && s_r.pfd_s[1] && ref_rise) begin
            s_nxt.up = s_r.st == plc_pkg::PLC_ST_ACQ; // R5
            s_nxt.dn = s_r.st == plc_pkg::PLC_ST_LOCK; // R5
        end
        if (ifa.tick) begin
            s_nxt.oa = !s_r.oa;
        end
        if (ifb.tick) begin
            s_nxt.ob = !s_r.ob;
        end
        if (ife.tick) begin
            s_nxt.oe = !s_r.oe;
        end
        s_nxt.lock = s_nxt.st == plc_pkg::PLC_ST_LOCK; // R11
        if (!active) begin
            s_nxt.st = plc_pkg::PLC_ST_OFF; // R1 R3
            s_nxt.cnt = 32'h0000_0000; // R3
            s_nxt.oa = 1'b0; // R1
            s_nxt.ob = 1'b0;
            s_nxt.oe = 1'b0;
            s_nxt.lock = 1'b0;
            s_nxt.up = 1'b0;
            s_nxt.dn = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
            s_r.mult <= `PLC_MULT_RST;
            s_r.pre <= `PLC_DIV_RST;
            s_r.div_a <= `PLC_DIV_RST;
            s_r.div_b <= `PLC_DIV_RST;
            s_r.div_e <= `PLC_DIV_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign clk_out_a_o = s_r.oa;
    assign clk_out_b_o = s_r.ob;
    assign external_clock_output_o = s_r.oe;
    assign locked_o = s_r.lock;
    assign corr_up_o = s_r.up;
    assign corr_dn_o = s_r.dn;
    assign cfg_err_o = s_r.err;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_off_quiet;
        @(posedge clk_i) disable iff (!arst_n_i)
        !s_r.run_s[1] |=> !locked_o && !clk_out_a_o && !external_clock_output_o;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("outputs live while off"); // R1
    property p_restart;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_r.st == plc_pkg::PLC_ST_OFF && active && cfg_ok |=> s_r.st == plc_pkg::PLC_ST_ACQ;
    endproperty
    a_restart: assert property (p_restart) else $error("no acquisition restart"); // R2
    property p_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_r.clr_s[1] |=> s_r.cnt == 32'h0 && !locked_o && !clk_out_b_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not reset"); // R3
    // clear just released while the loop is wanted and settings are legal
    sequence s_clr_released;
        $fell(s_r.clr_s[1]) && s_r.run_s[1] && cfg_ok;
    endsequence
    property p_clr_rel;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_clr_released |=> s_r.st == plc_pkg::PLC_ST_ACQ;
    endproperty
    a_clr_rel: assert property (p_clr_rel) else $error("no restart after clear"); // R4
    property p_pfd_off;
        @(posedge clk_i) disable iff (!arst_n_i)
        !s_r.pfd_s[1] |=> !corr_up_o && !corr_dn_o;
    endproperty
    a_pfd_off: assert property (p_pfd_off) else $error("correction while detector off"); // R5
    property p_mult;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_r.st != plc_pkg::PLC_ST_OFF |-> s_r.mult >= `PLC_MULT_MIN && s_r.mult <= `PLC_MULT_MAX;
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier out of range"); // R9
    property p_lock_time;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(locked_o) |-> s_r.cnt == 32'(LOCK_CYC);
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("lock at wrong time"); // R10
    property p_lock_st;
        @(posedge clk_i) disable iff (!arst_n_i)
        locked_o |-> s_r.st == plc_pkg::PLC_ST_LOCK;
    endproperty
    a_lock_st: assert property (p_lock_st) else $error("lock without locked state"); // R11
    property p_div_rng;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_r.st != plc_pkg::PLC_ST_OFF |-> in_rng(s_r.pre, `PLC_DIV_MIN, `PLC_DIV_MAX) &&
            in_rng(s_r.div_a, `PLC_DIV_MIN, `PLC_DIV_MAX) &&
            in_rng(s_r.div_b, `PLC_DIV_MIN, `PLC_DIV_MAX) &&
            in_rng(s_r.div_e, `PLC_DIV_MIN, `PLC_DIV_MAX);
    endproperty
    a_div_rng: assert property (p_div_rng) else $error("divider out of range"); // R12
    property p_lock_acq;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(locked_o) |-> $past(s_r.st) == plc_pkg::PLC_ST_ACQ;
    endproperty
    a_lock_acq: assert property (p_lock_acq) else $error("lock without acquisition"); // R10
endmodule

// [inc/plc_defs.svh]
/*
 pll control constants: counter limits, lock timing and reset values.
 assumes inclusion by bare name; definitions only.
*/
// Functional notes
// R1 - run enable low: outputs low, lock dropped
// R2 - run enable high again restarts acquisition, resync
// R3 - counter clear resets counters, outputs, lock
// R4 - counter clear release restarts acquisition
// R5 - detector disabled: no correction, clocks keep running
// R6 - run enable from fabric or any pin
// R7 - detector disable as holdover without reference
// R8 - reference clock only from dedicated pins
// R9 - feedback multiplier accepts only 2 to 32
// R10 - lock takes 10 to 100 us
// R11 - lock status high locked, may pulse
// R12 - other dividers accept 1 to 32
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH
`define PLC_MULT_MIN 6'h02
`define PLC_MULT_MAX 6'h20
`define PLC_DIV_MIN 6'h01
`define PLC_DIV_MAX 6'h20
`define PLC_MULT_RST 6'h02
`define PLC_DIV_RST 6'h01
`define PLC_CLK_MHZ 40
`define PLC_LOCK_MIN_US 10
`define PLC_LOCK_MAX_US 100
`define PLC_LOCK_MIN_CYC (`PLC_LOCK_MIN_US * `PLC_CLK_MHZ)
`define PLC_LOCK_MAX_CYC (`PLC_LOCK_MAX_US * `PLC_CLK_MHZ)
`define PLC_LOCK_DFLT_CYC 32'd1000
`endif

// [inc/plc_pkg.sv]
/*
 types shared by the pll control modules.
 assumes the defs header sits on the include path.
*/
package plc_pkg;
    typedef enum logic [1:0] {
        PLC_ST_OFF = 2'b00,
        PLC_ST_ACQ = 2'b01,
        PLC_ST_LOCK = 2'b10
    } plc_state_t;
endpackage

// [inc/plc_div_if.sv]
/*
 interface between the lock controller and an output divider.
 assumes one clock shared by both ends.
*/
interface plc_div_if;
    logic run;
    logic [5:0] ratio;
    logic tick;
    modport ctl (output run, output ratio, input tick);
    modport div (input run, input ratio, output tick);
endinterface

// [logic/plc_divider.sv]
/*
 programmable divider model of one loop counter; emits a one-cycle tick.
 assumes ratio already range-checked by the controller.
*/
`include "plc_defs.svh"
module plc_divider (
    input wire logic clk_i,
    input wire logic arst_n_i,
    plc_div_if.div d
);
    typedef struct packed {
        logic [5:0] cnt_r;
        logic tick_r;
    } plc_div_st_t;
    plc_div_st_t s_r;
    plc_div_st_t s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick_r = 1'b0;
        if (!d.run) begin
            s_nxt.cnt_r = 6'h00; // R3
        end else if (s_r.cnt_r + 6'h01 >= d.ratio) begin
            s_nxt.cnt_r = 6'h00;
            s_nxt.tick_r = 1'b1;
        end else begin
            s_nxt.cnt_r = s_r.cnt_r + 6'h01;
        end
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign d.tick = s_r.tick_r;
endmodule

// [test/plc_ref_model.sv]
/*
 far-side model: the dedicated reference clock pin of the loop.
 assumes it runs on the bench clock; stopping it mimics a lost reference.
*/
module plc_ref_model #(
    parameter int HALF = 3
) (
    input wire logic clk_i,
    input wire logic run_i,
    output logic ref_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic ref_r = 1'b0;
    // only this pin model feeds the reference, never fabric logic
    // stopped reference parks low, as a lost source would
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt <= 0;
            ref_r <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            ref_r <= ~ref_r;
        end else begin
            cnt <= cnt + 1;
        end
    end
    assign ref_o = ref_r;
endmodule

// [test/plc_ctrl_tb.sv]
/*
 self-checking bench for the pll control block.
 assumes plc_ctrl and the reference pin model; lock count shortened to 8.
*/
module plc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 8;
    logic clk_i = 1'b0, arst_n_i = 1'b0, run = 1'b0, clr = 1'b0, det = 1'b1, ref_run = 1'b1;
    logic [5:0] mult = 6'h04, pre = 6'h01, div_a = 6'h04, div_b = 6'h02, div_e = 6'h03;
    logic ref_clk, out_a, out_b, out_e, locked, up, dn, err;
    int num_errors = 0, comparisons = 0, cycles = 0, n, tga, tgb, tge, pd;
    logic [5:0] mvals [5] = '{6'h01, 6'h21, 6'h00, 6'h02, 6'h20};
    logic merr [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [5:0] dvals [4] = '{6'h00, 6'h21, 6'h01, 6'h20};
    logic derr [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    always #12.5 clk_i = ~clk_i;
    plc_ref_model #(.HALF(3)) REF (.clk_i(clk_i), .run_i(ref_run), .ref_o(ref_clk));
    plc_ctrl #(.LOCK_CYC(LOCK)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .loop_run_en_i(run), .counter_clear_i(clr), .detector_en_i(det),
        .reference_clock_in(ref_clk), .mult_i(mult), .prescale_i(pre),
        .internal_out_divider_a_i(div_a), .internal_out_divider_b_i(div_b),
        .external_out_divider_i(div_e), .clk_out_a_o(out_a), .clk_out_b_o(out_b),
        .external_clock_output_o(out_e), .locked_o(locked), .corr_up_o(up),
        .corr_dn_o(dn), .cfg_err_o(err));
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard: whole run should need well under this
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    // bounded wait for lock; n counts cycles from the call
    task automatic wait_lock();
        n = 0;
        while (locked !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    // count output toggles and correction pulses over 40 cycles
    // sampled on the falling edge so registered outputs have settled
    task automatic watch();
        logic la, lb, le;
        tga = 0;
        tgb = 0;
        tge = 0;
        pd = 0;
        la = out_a;
        lb = out_b;
        le = out_e;
        repeat (40) begin
            @(negedge clk_i);
            if (out_a !== la) tga++;
            if (out_b !== lb) tgb++;
            if (out_e !== le) tge++;
            if (dn === 1'b1 || up === 1'b1) pd++;
            la = out_a;
            lb = out_b;
            le = out_e;
        end
        @(posedge clk_i);
    endtask
    task automatic all_low();
        chk1(locked, 1'b0);
        chk1(out_a, 1'b0);
        chk1(out_b, 1'b0);
        chk1(out_e, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(4);
        arst_n_i <= 1'b1;
        cyc(10);
        all_low();
        run <= 1'b1;
        wait_lock();
        chk_rng(n, LOCK, LOCK + 12);
        chk1(err, 1'b0);
        watch();
        chk_rng(tga, 9, 11);
        chk_rng(tgb, 19, 21);
        chk_rng(tge, 12, 15);
        chk_rng(pd, 4, 8);
        chk1(locked, 1'b1);
        det <= 1'b0;
        cyc(4);
        watch();
        chk_rng(pd, 0, 0);
        chk_rng(tga, 9, 11);
        ref_run <= 1'b0;
        cyc(4);
        watch();
        chk_rng(tga, 9, 11);
        chk1(locked, 1'b1);
        det <= 1'b1;
        ref_run <= 1'b1;
        clr <= 1'b1;
        cyc(5);
        all_low();
        clr <= 1'b0;
        wait_lock();
        chk_rng(n, LOCK, LOCK + 12);
        run <= 1'b0;
        cyc(5);
        all_low();
        for (int i = 0; i < 5; i++) begin
            mult <= mvals[i];
            cyc(2);
            run <= 1'b1;
            cyc(8);
            chk1(err, merr[i]);
            run <= 1'b0;
            cyc(5);
        end
        for (int i = 0; i < 4; i++) begin
            div_b <= dvals[i];
            cyc(2);
            run <= 1'b1;
            cyc(8);
            chk1(err, derr[i]);
            run <= 1'b0;
            cyc(5);
        end
        final_report();
    end
endmodule
